// *** p5g_port.sv ***
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module p5g_port
  import p5g_pkg::*;
(
  input wire logic sys_clk_in, // 125 MHz system clock
  input wire logic resetn_in, // async reset, active low
  input wire logic [P5G_ADDR_W-1:0] addr_in, // register byte address
  input wire logic [P5G_DATA_W-1:0] wdata_in, // write data
  input wire logic wr_in, // write strobe, one cycle
  input wire logic rd_in, // read strobe, one cycle
  output logic [P5G_DATA_W-1:0] rdata_out, // read data, cycle after rd_in
  input wire logic [P5G_PINS-1:0] port_pin_in, // pin levels from the pads
  output logic [P5G_PINS-1:0] port_pin_out, // pin drive values
  output logic [P5G_PINS-1:0] port_pin_oe_out, // pin drive enables, high drives
  output logic [P5G_WAKE_PINS-1:0] wake_event_out, // falling edge on a wake pin
  output logic conversion_trigger_out // falling edge on trigger pin
);
  logic [P5G_PINS-1:0] function_select_register;
  logic [P5G_PINS-1:0] direction_register;
  logic [P5G_PINS-1:0] output_latch_register;
  logic [P5G_WAKE_PINS-1:0] wake_flag;
  logic [P5G_PINS-1:0] next_pin_out;
  logic [P5G_PINS-1:0] next_pin_oe;
  logic [P5G_PINS-1:0] port_read_value;
  logic [P5G_WAKE_PINS-1:0] wake_sel;
  logic [P5G_WAKE_PINS-1:0] wake_hit;
  logic [P5G_DATA_W-1:0] next_rdata;
  logic sel_fsel;
  logic sel_dir;
  logic sel_latch;
  logic sel_flag;

  p5g_sync_if pins ();

  assign pins.raw = port_pin_in;

  p5g_pin_sync u_sync (
    .clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .sync(pins.sync_side)
  );

  assign sel_fsel = (addr_in == P5G_FSEL_ADDR);
  assign sel_dir = (addr_in == P5G_DIR_ADDR);
  assign sel_latch = (addr_in == P5G_LATCH_ADDR);
  assign sel_flag = (addr_in == P5G_WAKE_FLAG_ADDR);

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      function_select_register <= P5G_FSEL_RST;
    else if (wr_in && sel_fsel)
      function_select_register <= wdata_in;
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      direction_register <= P5G_DIR_RST;
    else if (wr_in && sel_dir)
      direction_register <= wdata_in;
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      output_latch_register <= P5G_LATCH_RST;
    else if (wr_in && sel_latch)
      output_latch_register <= wdata_in;
  end

  // pin mode decode; wake pins never drive, open-drain pins only pull low
  always_comb
  begin
    next_pin_out = '0;
    next_pin_oe = '0;
    for (int i = 0; i < P5G_PINS; i++)
    begin
      if (function_select_register[i] && i >= P5G_OD_LOWEST)
      begin
        next_pin_out[i] = 1'b0;
        next_pin_oe[i] = direction_register[i] & ~output_latch_register[i];
      end
      else if (function_select_register[i])
      begin
        next_pin_out[i] = 1'b0;
        next_pin_oe[i] = 1'b0;
      end
      else
      begin
        next_pin_out[i] = output_latch_register[i];
        next_pin_oe[i] = direction_register[i];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      port_pin_out <= '0;
      port_pin_oe_out <= '0;
    end
    else
    begin
      port_pin_out <= next_pin_out;
      port_pin_oe_out <= next_pin_oe;
    end
  end

  // wake inputs are active low, so a falling edge is the event
  assign wake_sel = function_select_register[P5G_WAKE_PINS-1:0];
  assign wake_hit = wake_sel & pins.fall[P5G_WAKE_PINS-1:0];

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wake_event_out <= '0;
      conversion_trigger_out <= 1'b0;
    end
    else
    begin
      wake_event_out <= wake_hit;
      conversion_trigger_out <= wake_hit[P5G_TRIG_PIN];
    end
  end

  // sticky record of wake events, write one to clear; a new event wins
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      wake_flag <= P5G_WAKE_FLAG_RST;
    else if (wr_in && sel_flag)
      wake_flag <= (wake_flag & ~wdata_in[P5G_WAKE_PINS-1:0]) | wake_hit;
    else
      wake_flag <= wake_flag | wake_hit;
  end

  // outputs read back the latch, inputs read the synchronised pin
  assign port_read_value = (direction_register & output_latch_register)
                         | (~direction_register & pins.level);

  always_comb
  begin
    next_rdata = P5G_UNMAPPED_RD;
    if (sel_fsel)
      next_rdata = function_select_register;
    else if (sel_latch)
      next_rdata = port_read_value;
    else if (sel_flag)
      next_rdata = {{(P5G_DATA_W-P5G_WAKE_PINS){1'b0}}, wake_flag};
    else if (sel_dir)
      next_rdata = P5G_UNMAPPED_RD;
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rdata_out <= P5G_RDATA_RST;
    else if (rd_in)
      rdata_out <= next_rdata;
    else
      rdata_out <= P5G_RDATA_RST;
  end
endmodule // p5g_port
`default_nettype wire

// *** p5g_pkg.sv ***
package p5g_pkg;
  localparam int P5G_PINS = 8;
  localparam int P5G_WAKE_PINS = 6;
  localparam int P5G_ADDR_W = 8;
  localparam int P5G_DATA_W = 8;

  // register byte addresses
  localparam logic [P5G_ADDR_W-1:0] P5G_FSEL_ADDR = 8'h00;
  localparam logic [P5G_ADDR_W-1:0] P5G_DIR_ADDR = 8'h04;
  localparam logic [P5G_ADDR_W-1:0] P5G_LATCH_ADDR = 8'h08;
  localparam logic [P5G_ADDR_W-1:0] P5G_WAKE_FLAG_ADDR = 8'h0C;

  // reset values
  localparam logic [P5G_PINS-1:0] P5G_FSEL_RST = 8'h00;
  localparam logic [P5G_PINS-1:0] P5G_DIR_RST = 8'h00;
  localparam logic [P5G_PINS-1:0] P5G_LATCH_RST = 8'h00;
  localparam logic [P5G_WAKE_PINS-1:0] P5G_WAKE_FLAG_RST = 6'h00;
  localparam logic [P5G_DATA_W-1:0] P5G_RDATA_RST = 8'h00;
  localparam logic [P5G_DATA_W-1:0] P5G_UNMAPPED_RD = 8'h00;

  // field positions in the function-select register
  localparam int P5G_OPEN_DRAIN_SEL_PIN7 = 7;
  localparam int P5G_OPEN_DRAIN_SEL_PIN6 = 6;
  localparam int P5G_WAKE_IN_SEL_5 = 5;
  localparam int P5G_WAKE_IN_SEL_LO = 0;
  localparam int P5G_WAKE_IN_SEL_HI = 4;
  localparam int P5G_TRIG_PIN = 5;
  localparam int P5G_OD_LOWEST = 6;

  // synchroniser reset level: pins idle high (wake inputs are active low)
  localparam logic [P5G_PINS-1:0] P5G_SYNC_RST = 8'hFF;
endpackage

// *** p5g_sync_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface p5g_sync_if;
  import p5g_pkg::*;
  logic [P5G_PINS-1:0] raw;
  logic [P5G_PINS-1:0] level;
  logic [P5G_PINS-1:0] fall;

  modport sync_side (input raw, output level, output fall);
  modport user_side (output raw, input level, input fall);
endinterface // p5g_sync_if
`default_nettype wire

// *** p5g_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module p5g_pin_sync
  import p5g_pkg::*;
(
  input wire logic clk_in, // system clock
  input wire logic resetn_in, // async reset, active low
  p5g_sync_if.sync_side sync // raw pins in, clean levels out
);
  logic [P5G_PINS-1:0] stage1;
  logic [P5G_PINS-1:0] stage2;
  logic [P5G_PINS-1:0] stage3;
  logic [P5G_PINS-1:0] level;
  logic [P5G_PINS-1:0] fall;
  logic [P5G_PINS-1:0] agree;

  // stage1 feeds only stage2
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      stage1 <= P5G_SYNC_RST;
      stage2 <= P5G_SYNC_RST;
      stage3 <= P5G_SYNC_RST;
    end
    else
    begin
      stage1 <= sync.raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign agree = ~(stage2 ^ stage3);

  // a change counts only once stages two and three agree
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      level <= P5G_SYNC_RST;
      fall <= '0;
    end
    else
    begin
      level <= (agree & stage3) | (~agree & level);
      fall <= agree & level & ~stage3;
    end
  end

  assign sync.level = level;
  assign sync.fall = fall;
endmodule // p5g_pin_sync
`default_nettype wire

// *** p5g_port_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module p5g_port_sva
  import p5g_pkg::*;
(
  input wire logic sys_clk_in, // clock
  input wire logic resetn_in, // reset
  input wire logic [P5G_ADDR_W-1:0] addr_in, // address
  input wire logic [P5G_DATA_W-1:0] wdata_in, // data
  input wire logic wr_in, // write
  input wire logic rd_in, // read
  input wire logic [P5G_DATA_W-1:0] rdata_out, // read data
  input wire logic [P5G_PINS-1:0] port_pin_out, // drive
  input wire logic [P5G_PINS-1:0] port_pin_oe_out, // enable
  input wire logic [P5G_WAKE_PINS-1:0] wake_event_out, // wake
  input wire logic conversion_trigger_out // trigger
);
  // shadow of select, direction and latch, indexed by address bits 3:2
  logic [2:0][7:0] sh;
  logic [7:0] exp_oe;
  always_ff @(posedge sys_clk_in or negedge resetn_in)
    if (!resetn_in)
      sh <= '0;
    else if (wr_in && addr_in < P5G_WAKE_FLAG_ADDR && addr_in[1:0] == 2'b00)
      sh[addr_in[3:2]] <= wdata_in;
  assign exp_oe = sh[1] & ~{sh[0][7:6] & sh[2][7:6], sh[0][5:0]};
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  chk_oe_follows_regs: assert property (port_pin_oe_out == $past(exp_oe))
    else $error("pin enable wrong");
  chk_out_is_latch: assert property
    ((port_pin_out & port_pin_oe_out) == ($past(sh[2]) & port_pin_oe_out))
    else $error("pin value wrong");
  chk_od_pin7_low: assert property ($past(sh[0][7]) |-> !port_pin_out[7])
    else $error("open drain pin 7 drives high");
  chk_od_pin6_low: assert property ($past(sh[0][6]) |-> !port_pin_out[6])
    else $error("open drain pin 6 drives high");
  chk_rd_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside its cycle");
  chk_dir_write_only: assert property
    (rd_in && addr_in == P5G_DIR_ADDR |=> rdata_out == 8'h00)
    else $error("direction register readable");
  chk_rd_out_bits: assert property
    (rd_in && addr_in == P5G_LATCH_ADDR |=> (rdata_out & sh[1]) == (sh[2] & sh[1]))
    else $error("output bits read wrong");
  chk_trig_with_wake: assert property (conversion_trigger_out == wake_event_out[5])
    else $error("trigger and wake on pin 5 differ");
  chk_wake_only_sel: assert property
    ((wake_event_out & ~$past(sh[0][5:0])) == 6'h00)
    else $error("wake event on unselected pin");
endmodule // p5g_port_sva
bind p5g_port p5g_port_sva u_sva (.sys_clk_in, .resetn_in, .addr_in, .wdata_in, .wr_in,
  .rd_in, .rdata_out, .port_pin_out, .port_pin_oe_out, .wake_event_out,
  .conversion_trigger_out);
`default_nettype wire

// *** p5g_pads.sv ***
`timescale 1ns/1ps
`default_nettype none
module p5g_pads
  import p5g_pkg::*;
(
  input wire logic [P5G_PINS-1:0] drive_in, // values from the port
  input wire logic [P5G_PINS-1:0] oe_in, // enables from the port
  input wire logic [P5G_PINS-1:0] ext_in, // level the outside pulls to
  output logic [P5G_PINS-1:0] level_out // resolved wire level
);
  // an enabled port drive wins over the weak outside source
  assign level_out = (oe_in & drive_in) | (~oe_in & ext_in);
endmodule // p5g_pads
`default_nettype wire

// *** port5_gpio_with_wakeup_select_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module port5_gpio_with_wakeup_select_tb_top;
  import p5g_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  // outside pins idle high: wake inputs are active low, so a low idle fakes falls
  logic [7:0] addr = 8'h00, wdat = 8'h00, ext = 8'hFF, rdat, pout, poe, lvl;
  logic [5:0] wake;
  logic trig;
  logic [31:0] seed = 32'h00011C70;
  byte unsigned m_fsel, m_dir, m_lat;
  int failures = 0, n_compared = 0, n;
  always #4 clk = ~clk;
  p5g_port DUT (.sys_clk_in(clk), .resetn_in(rst_n), .addr_in(addr), .wdata_in(wdat),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdat), .port_pin_in(lvl), .port_pin_out(pout),
    .port_pin_oe_out(poe), .wake_event_out(wake), .conversion_trigger_out(trig));
  p5g_pads PADS (.drive_in(pout), .oe_in(poe), .ext_in(ext), .level_out(lvl));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [7:0] m_oe();
    return m_dir & ~{m_fsel[7:6] & m_lat[7:6], m_fsel[5:0]};
  endfunction
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e, input string what);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(what, e, rdat);
  endtask
  task automatic report_and_stop();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    failures++;
    report_and_stop();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("oe", 8'h00, poe);
    rreg(P5G_FSEL_ADDR, 8'h00, "fsel");
    rreg(P5G_LATCH_ADDR, 8'hFF, "pins");
    wreg(P5G_DIR_ADDR, 8'hFF);
    rreg(P5G_LATCH_ADDR, 8'h00, "latch");
    $display("test reset done");
    repeat (40)
    begin
      seed = xs(seed);
      m_fsel = seed[7:0];
      m_dir = seed[15:8];
      m_lat = seed[23:16];
      wreg(P5G_FSEL_ADDR, m_fsel);
      wreg(P5G_DIR_ADDR, m_dir);
      wreg(P5G_LATCH_ADDR, m_lat);
      ext <= seed[31:24];
      repeat (6) @(posedge clk);
      #1 chk("oe", m_oe(), poe);
      chk("out", m_lat & m_oe(), pout & poe);
      rreg(P5G_FSEL_ADDR, m_fsel, "fsel");
      rreg(P5G_DIR_ADDR, 8'h00, "dir");
      rreg(P5G_LATCH_ADDR, (m_dir & m_lat) | (~m_dir & ext), "latch");
    end
    $display("test random done");
    wreg(P5G_FSEL_ADDR, 8'h3F);
    wreg(P5G_DIR_ADDR, 8'hFF);
    ext <= 8'hFF;
    repeat (6) @(posedge clk);
    #1 chk("wake oe", 8'hC0, poe);
    @(posedge clk);
    ext <= 8'h00;
    n = 0;
    while (wake !== 6'h3F && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    chk("wake", 8'h3F, {2'b00, wake});
    chk("trigger", 8'h01, {7'h00, trig});
    rreg(P5G_WAKE_FLAG_ADDR, 8'h3F, "wake flag");
    wreg(P5G_WAKE_FLAG_ADDR, 8'h3F);
    rreg(P5G_WAKE_FLAG_ADDR, 8'h00, "wake flag clear");
    rreg(8'h10, 8'h00, "unmapped");
    $display("test wake done");
    wreg(P5G_LATCH_ADDR, 8'hA5);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("oe", 8'h00, poe);
    rreg(P5G_FSEL_ADDR, 8'h00, "fsel");
    wreg(P5G_DIR_ADDR, 8'hFF);
    rreg(P5G_LATCH_ADDR, 8'h00, "latch");
    $display("test second reset done");
    report_and_stop();
  end
endmodule // port5_gpio_with_wakeup_select_tb_top
`default_nettype wire
